/* File: design/ctm_pkg.sv */
// package: register map, field layout and types of the compact 10-bit timer
package ctm_pkg;
  localparam int unsigned CNT_W = 10;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_CTRL0  = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL1  = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CNT_LO = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_CNT_HI = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_CMPA_LO = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_CMPA_HI = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h6;

  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_MAX    = 10'h3ff;
  localparam logic [CNT_W-1:0]  CNT_ZERO   = 10'h000;
  localparam logic [2:0]        CMPP_ZERO  = 3'h0;
  localparam int unsigned       CMPP_LSB   = 7;
  localparam int unsigned       HI_W       = 2;

  localparam int unsigned C0_PAUSE = 7;
  localparam int unsigned C0_CLK_HI = 6;
  localparam int unsigned C0_CLK_LO = 4;
  localparam int unsigned C0_ENABLE = 3;
  localparam int unsigned C0_CMPP_HI = 2;
  localparam int unsigned C0_CMPP_LO = 0;

  localparam int unsigned ST_AF = 0;
  localparam int unsigned ST_PF = 1;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_UNDEF   = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_TIMER   = 2'b11
  } mode_e;

  typedef enum logic [2:0] {
    CK_SYS_DIV4 = 3'h0,
    CK_SYS      = 3'h1,
    CK_H_DIV16  = 3'h2,
    CK_H_DIV64  = 3'h3,
    CK_SUB_A    = 3'h4,
    CK_SUB_B    = 3'h5,
    CK_EXT_RISE = 3'h6,
    CK_EXT_FALL = 3'h7
  } clk_sel_e;

  localparam logic [5:0] DIV4_MASK  = 6'h03;
  localparam logic [5:0] DIV16_MASK = 6'h0f;
  localparam logic [5:0] DIV64_MASK = 6'h3f;

  typedef struct packed {
    mode_e      mode;
    logic [1:0] pin_action;
    logic       out_init;
    logic       out_inv;
    logic       swap;
    logic       clr_sel;
  } ctrl1_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_s;
endpackage

/* File: design/compact_10bit_timer_pwm.sv */
// compact 10-bit timer with compare match, pwm and timer/counter modes
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// - compare mode: initial level bit sets pin before any match; unused in timer mode.
// - pwm mode: initial level bit picks active level of waveform.
// - invert bit flips the pin; no effect in timer/counter mode.
// - swap 0: p sets period, a duty; swap 1 the reverse.
// - clear select 1 clears on a match; 0 on p match or overflow.
// - with clear select 0, overflow clear only when p value is zero.
// - pwm mode ignores clear select; period comparator alone clears.
// - counter readable as low byte plus two high bits, rest zero.
// - compare a held in low byte plus two high bits, rest zero.
// - mode 00 compare, 10 pwm, 11 timer/counter.
// - compare mode, clear select 0: both a and p flags set on matches.
// - compare and timer modes, clear select 1: only a flag, never p flag.
// - clear select 1 and a zero: overflow at 3ff without a flag.
// - compare mode: pin changes only on a flag match, never on p.
// - enable rising edge loads initial level; action 00 gives no change.
// - timer/counter mode acts as compare mode but pin not driven.
// - pwm: one comparator clears counter (frequency), other sets duty.
// - pwm: a and p flags set on their matches.
// - pwm: counting, clearing and flags run while pin forced by 00/01.
// - swap 0: period p*128 clocks, 1024 for zero; duty equals a.
// - duty at or above period gives output active whole period.
// - swap 1: period equals a; duty p*128, 1024 for zero.
// - action: compare none/low/high/toggle; pwm inactive/active/wave/undefined.
// - enable rise zeroes counter; enable fall holds residual value.
module compact_10bit_timer_pwm (
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  input  wire ctm_pkg::bus_req_s     bus_i,
  input  wire logic                  h_tick_i,
  input  wire logic                  sub_tick_i,
  input  wire logic                  ext_clk_i,
  output logic [ctm_pkg::DATA_W-1:0] rdata_o,
  output logic                       pin_o,
  output logic                       pin_oe_o,
  output logic                       flag_a_o,
  output logic                       flag_p_o
);
  import ctm_pkg::*;

  logic [DATA_W-1:0] ctrl0_r;
  ctrl1_s            ctrl1_r;
  logic [CNT_W-1:0]  cmpa_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic              flag_a_r;
  logic              flag_p_r;
  logic              en_d_r;
  logic              pin_r;
  logic              pin_oe_r;
  logic              cmp_lvl_r;
  logic [DATA_W-1:0] rdata_r;
  logic [5:0]        sys_div_r;
  logic [5:0]        h_div_r;
  logic [2:0]        ext_sync_r;
  logic              tick;
  logic              enable;
  logic              en_rise;
  logic [2:0]        cmpp;
  logic              match_a;
  logic              match_p;
  logic              at_max;
  logic              clear;
  logic              set_a;
  logic              set_p;
  logic              pwm_act;
  logic [CNT_W:0]    period;
  logic [CNT_W:0]    duty;
  logic              lvl;

  // p comparator value scaled to counts, zero meaning full range
  function automatic logic [CNT_W:0] p_span(input logic [2:0] p);
    p_span = (p == CMPP_ZERO) ? {1'b1, CNT_ZERO} : {1'b0, p, 7'h00};
  endfunction

  assign enable  = ctrl0_r[C0_ENABLE];
  assign en_rise = enable & ~en_d_r;
  assign cmpp    = ctrl0_r[C0_CMPP_HI:C0_CMPP_LO];
  assign at_max  = (cnt_r == CNT_MAX);

  ////////////////////////////////////////////////////////////////////////////////
  // counting clock selection; pin clock resynchronised before edge detect
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ext_sync_r <= 3'h0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], ext_clk_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sys_div_r <= 6'h00;
    end else begin
      sys_div_r <= sys_div_r + 6'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      h_div_r <= 6'h00;
    end else if (h_tick_i) begin
      h_div_r <= h_div_r + 6'h01;
    end
  end

  always_comb begin
    case (clk_sel_e'(ctrl0_r[C0_CLK_HI:C0_CLK_LO]))
      CK_SYS_DIV4: tick = ((sys_div_r & DIV4_MASK) == 6'h00);
      CK_SYS:      tick = 1'b1;
      CK_H_DIV16:  tick = h_tick_i & ((h_div_r & DIV16_MASK) == 6'h00);
      CK_H_DIV64:  tick = h_tick_i & ((h_div_r & DIV64_MASK) == 6'h00);
      CK_SUB_A:    tick = sub_tick_i;
      CK_SUB_B:    tick = sub_tick_i;
      CK_EXT_RISE: tick = ext_sync_r[1] & ~ext_sync_r[2];
      CK_EXT_FALL: tick = ~ext_sync_r[1] & ext_sync_r[2];
      default:     tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // comparators; a match is taken on the tick that reaches the value
  always_comb begin
    match_a = 1'b0;
    match_p = 1'b0;
    clear   = 1'b0;
    period  = p_span(cmpp);
    duty    = {1'b0, cmpa_r};
    if (ctrl1_r.mode == MODE_PWM) begin
      if (ctrl1_r.swap) begin
        period = {1'b0, cmpa_r};
        duty   = p_span(cmpp);
      end
      match_a = ({1'b0, cnt_r} + 11'h001) == {1'b0, cmpa_r};
      match_p = ({1'b0, cnt_r} + 11'h001) == p_span(cmpp);
      // period comparator alone clears; clear select ignored
      clear = ctrl1_r.swap ? match_a : match_p;
    end else begin
      match_a = (cmpa_r != CNT_ZERO) && (cnt_r + 10'h001 == cmpa_r);
      match_p = (cmpp != CMPP_ZERO) && !ctrl1_r.clr_sel &&
                ({1'b0, cnt_r} + 11'h001 == {1'b0, cmpp, 7'h00});
      if (ctrl1_r.clr_sel) begin
        clear = match_a;
      end else begin
        clear = match_p | ((cmpp == CMPP_ZERO) & at_max);
      end
    end
    set_a = tick & enable & ~ctrl0_r[C0_PAUSE] & match_a;
    set_p = tick & enable & ~ctrl0_r[C0_PAUSE] & match_p;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // counter
  always_comb begin
    cnt_nxt = cnt_r;
    if (en_rise) begin
      cnt_nxt = CNT_ZERO;
    end else if (enable && !ctrl0_r[C0_PAUSE] && tick) begin
      cnt_nxt = clear ? CNT_ZERO : cnt_r + 10'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_r  <= CNT_ZERO;
      en_d_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      en_d_r <= enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // flags: hardware set wins over software clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flag_a_r <= 1'b0;
      flag_p_r <= 1'b0;
    end else begin
      flag_a_r <= set_a | (flag_a_r &
                  ~(bus_i.wr && bus_i.addr == ADDR_STATUS && bus_i.wdata[ST_AF]));
      flag_p_r <= set_p | (flag_p_r &
                  ~(bus_i.wr && bus_i.addr == ADDR_STATUS && bus_i.wdata[ST_PF]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare-mode level, held before the invert stage
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cmp_lvl_r <= 1'b0;
    end else if (en_rise) begin
      cmp_lvl_r <= ctrl1_r.out_init;
    end else if (set_a && ctrl1_r.mode == MODE_COMPARE) begin
      case (ctrl1_r.pin_action)
        2'b00:   cmp_lvl_r <= cmp_lvl_r;
        2'b01:   cmp_lvl_r <= 1'b0;
        2'b10:   cmp_lvl_r <= 1'b1;
        2'b11:   cmp_lvl_r <= ~cmp_lvl_r;
        default: cmp_lvl_r <= cmp_lvl_r;
      endcase
    end
  end

  // pwm active while counter below duty; duty at or above period stays active
  always_comb begin
    pwm_act = ({1'b0, cnt_r} < duty) || (duty >= period);
    case (ctrl1_r.pin_action)
      2'b00:   lvl = ~ctrl1_r.out_init;
      2'b01:   lvl = ctrl1_r.out_init;
      2'b10:   lvl = pwm_act ? ctrl1_r.out_init : ~ctrl1_r.out_init;
      default: lvl = ~ctrl1_r.out_init;  // undefined code parks inactive
    endcase
    if (ctrl1_r.mode != MODE_PWM) begin
      lvl = cmp_lvl_r;
    end
  end

  // timer mode releases the pin for other uses
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_r    <= 1'b0;
      pin_oe_r <= 1'b0;
    end else begin
      pin_r    <= lvl ^ ctrl1_r.out_inv;
      pin_oe_r <= (ctrl1_r.mode == MODE_COMPARE) ||
                  (ctrl1_r.mode == MODE_PWM);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register writes; mode and action changes meant only while stopped
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl0_r <= CTRL_RESET;
      ctrl1_r <= ctrl1_s'(CTRL_RESET);
      cmpa_r  <= CNT_ZERO;
    end else if (bus_i.wr) begin
      case (bus_i.addr)
        ADDR_CTRL0:   ctrl0_r <= bus_i.wdata;
        ADDR_CTRL1:   ctrl1_r <= ctrl1_s'(bus_i.wdata);
        ADDR_CMPA_LO: cmpa_r[DATA_W-1:0] <= bus_i.wdata;
        ADDR_CMPA_HI: cmpa_r[CNT_W-1:DATA_W] <= bus_i.wdata[HI_W-1:0];
        default:      ctrl0_r <= ctrl0_r;
      endcase
    end
  end

  // read data one cycle after the strobe, zero otherwise and for holes
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_r <= 8'h00;
    end else if (bus_i.rd) begin
      case (bus_i.addr)
        ADDR_CTRL0:   rdata_r <= ctrl0_r;
        ADDR_CTRL1:   rdata_r <= DATA_W'(ctrl1_r);
        ADDR_CNT_LO:  rdata_r <= cnt_r[DATA_W-1:0];
        ADDR_CNT_HI:  rdata_r <= {6'h00, cnt_r[CNT_W-1:DATA_W]};
        ADDR_CMPA_LO: rdata_r <= cmpa_r[DATA_W-1:0];
        ADDR_CMPA_HI: rdata_r <= {6'h00, cmpa_r[CNT_W-1:DATA_W]};
        ADDR_STATUS:  rdata_r <= {6'h00, flag_p_r, flag_a_r};
        default:      rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata_o  = rdata_r;
  assign pin_o    = pin_r;
  assign pin_oe_o = pin_oe_r;
  assign flag_a_o = flag_a_r;
  assign flag_p_o = flag_p_r;
endmodule // compact_10bit_timer_pwm

/* File: tb/compact_10bit_timer_pwm_asserts.sv */
// checker: port-level properties of the compact timer
`timescale 1ns/1ps
module compact_10bit_timer_pwm_asserts
  import ctm_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  srst_i,
  input wire ctm_pkg::bus_req_s     bus_i,
  input wire logic                  h_tick_i,
  input wire logic                  sub_tick_i,
  input wire logic                  ext_clk_i,
  input wire logic [ctm_pkg::DATA_W-1:0] rdata_o,
  input wire logic                  pin_o,
  input wire logic                  pin_oe_o,
  input wire logic                  flag_a_o,
  input wire logic                  flag_p_o
);
  ctrl1_s     c1_r;
  logic       en_r;
  logic [1:0] calm_r;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////////////////////
  // shadow of the control bits, taken off the bus
  always_ff @(posedge clk_i) begin
    if (srst_i) c1_r <= '0;
    else if (bus_i.wr && bus_i.addr == ADDR_CTRL1) c1_r <= ctrl1_s'(bus_i.wdata);
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) en_r <= 1'b0;
    else if (bus_i.wr && bus_i.addr == ADDR_CTRL0) en_r <= bus_i.wdata[C0_ENABLE];
  end
  // pin pipeline needs a few quiet cycles after any control write
  always_ff @(posedge clk_i) begin
    if (srst_i || (bus_i.wr && bus_i.addr <= ADDR_CTRL1)) calm_r <= 2'h0;
    else if (calm_r != 2'h3) calm_r <= calm_r + 2'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_RD_IDLE: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  AST_CNT_HI: assert property ($past(bus_i.rd && bus_i.addr == ADDR_CNT_HI) |-> rdata_o[7:2] == 6'h00)
    else $error("counter high spare bits set");
  AST_CMPA_HI: assert property ($past(bus_i.rd && bus_i.addr == ADDR_CMPA_HI) |-> rdata_o[7:2] == 6'h00)
    else $error("compare high spare bits set");
  AST_NO_PF: assert property (c1_r.clr_sel && c1_r.mode != MODE_PWM && $past(c1_r) == c1_r |-> !$rose(flag_p_o))
    else $error("p flag raised with a-clear");
  AST_OE: assert property (c1_r.mode != MODE_UNDEF && $past(c1_r.mode) == c1_r.mode && !$past(srst_i) |-> pin_oe_o == (c1_r.mode != MODE_TIMER))
    else $error("pin drive does not follow mode");
  AST_AF_HOLD: assert property (flag_a_o && !(bus_i.wr && bus_i.addr == ADDR_STATUS) |=> flag_a_o)
    else $error("a flag dropped by itself");
  AST_FORCE_ACT: assert property (calm_r == 2'h3 && en_r && c1_r.mode == MODE_PWM && c1_r.pin_action == 2'b01 |-> pin_o == (c1_r.out_init ^ c1_r.out_inv))
    else $error("forced active level wrong");
  AST_FORCE_INACT: assert property (calm_r == 2'h3 && en_r && c1_r.mode == MODE_PWM && c1_r.pin_action == 2'b00 |-> pin_o != (c1_r.out_init ^ c1_r.out_inv))
    else $error("forced inactive level wrong");
endmodule // compact_10bit_timer_pwm_asserts

/* File: tb/pin_load.sv */
// partner: load on the timer pin, counts driven-high cycles
`timescale 1ns/1ps
module pin_load (
  input  wire logic clk_i,
  input  wire logic clr_i,
  input  wire logic pin_i,
  input  wire logic oe_i,
  output int        hi_o
);
  // undriven pin reads low through the load's pull-down
  always_ff @(posedge clk_i) begin
    if (clr_i) hi_o <= 0;
    else if (oe_i && pin_i) hi_o <= hi_o + 1;
  end
endmodule // pin_load

/* File: tb/compact_10bit_timer_pwm_tb.sv */
// testbench: register, compare, overflow and pwm scenarios
`timescale 1ns/1ps
module compact_10bit_timer_pwm_tb;
  import ctm_pkg::*;
  logic       clk_i, srst_i, pin_o, pin_oe_o, flag_a_o, flag_p_o, clr;
  bus_req_s   bus_r;
  logic [7:0] rdata_o, d;
  int         n_fail, checks, hi;
  compact_10bit_timer_pwm i_compact_10bit_timer_pwm (.clk_i(clk_i), .srst_i(srst_i),
    .bus_i(bus_r), .h_tick_i(1'b0), .sub_tick_i(1'b0), .ext_clk_i(1'b0), .rdata_o(rdata_o),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .flag_a_o(flag_a_o), .flag_p_o(flag_p_o));
  pin_load i_pin_load (.clk_i(clk_i), .clr_i(clr), .pin_i(pin_o), .oe_i(pin_oe_o), .hi_o(hi));
  initial begin clk_i = 1'b0; forever #10 clk_i = ~clk_i; end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i) bus_r <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i) bus_r <= '0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk_i) bus_r <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i) bus_r <= '0;
    #1 d = rdata_o;
  endtask
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    rd(a);
    chk("register", e, d);
  endtask
  // stop first: mode and action may only change while stopped
  task automatic cfg(input logic [7:0] c1, input logic [9:0] a, input logic [7:0] c0);
    wr(ADDR_CTRL0, 8'h10);
    wr(ADDR_STATUS, 8'h03);
    wr(ADDR_CTRL1, c1);
    wr(ADDR_CMPA_LO, a[7:0]);
    wr(ADDR_CMPA_HI, {6'h00, a[9:8]});
    wr(ADDR_CTRL0, c0);
  endtask
  task automatic waitf(input int lim);
    for (int i = 0; i < lim && flag_a_o !== 1'b1; i++) begin @(posedge clk_i); #1; end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rc(ADDR_CNT_LO, 8'h00);
    rc(ADDR_CMPA_HI, 8'h00);
    wr(ADDR_CMPA_LO, 8'ha5);
    wr(ADDR_CMPA_HI, 8'hff);
    rc(ADDR_CMPA_LO, 8'ha5);
    rc(ADDR_CMPA_HI, 8'h03);
    wr(ADDR_CNT_LO, 8'h55);
    rc(ADDR_CNT_LO, 8'h00);
    rc(3'h7, 8'h00);
    $display("regs done");
  endtask
  task automatic t_cmp;
    logic [7:0] m [3] = '{8'h39, 8'h09, 8'hf1};
    foreach (m[i]) begin
      cfg(m[i], 10'd5, 8'h18);
      // enable lands, counter zeroes one edge later, pin register one more
      repeat (2) @(posedge clk_i);
      #1 if (i < 2) chk("pin init", 1, pin_o);
      waitf(20);
      chk("a flag", 1, flag_a_o);
      chk("p flag", 0, flag_p_o);
      chk("drive", i < 2, pin_oe_o);
      @(posedge clk_i);
      #1 if (i < 2) chk("pin match", m[i][5:4] == 2'b00, pin_o);
    end
    wr(ADDR_CTRL0, 8'h10);
    rd(ADDR_CNT_LO);
    m[0] = d;
    rc(ADDR_CNT_LO, m[0]);
    $display("compare done");
  endtask
  task automatic t_compare_p_value;
    cfg(8'h20, 10'd3, 8'h19);
    repeat (140) @(posedge clk_i);
    #1 chk("both flags", 2'b11, {flag_p_o, flag_a_o});
    chk("pin high", 1, pin_o);
    rc(ADDR_CNT_HI, 8'h00);
    wr(ADDR_CTRL0, 8'h10);
    wr(ADDR_STATUS, 8'h03);
    #1 chk("flags cleared", 0, {flag_p_o, flag_a_o});
    $display("p clear done");
  endtask
  task automatic t_ovf;
    cfg(8'h01, 10'd0, 8'h18);
    d = 8'h00;
    for (int i = 0; i < 600 && d !== 8'h03; i++) rd(ADDR_CNT_HI);
    chk("cnt top", 3, d);
    for (int i = 0; i < 200 && d !== 8'h00; i++) rd(ADDR_CNT_HI);
    chk("cnt wrap", 0, d);
    chk("no a flag", 0, flag_a_o);
    $display("overflow done");
  endtask
  task automatic pw(input logic [7:0] c1, input logic [9:0] a, input logic [2:0] p,
                    input int win, input logic [9:0] ex, input logic [1:0] fl);
    cfg(c1, a, {5'b00011, p});
    repeat (8) @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i) clr <= 1'b0;
    repeat (win) @(posedge clk_i);
    #1 chk("high count", ex, 10'(hi));
    chk("pwm flags", fl, {flag_p_o, flag_a_o});
  endtask
  task automatic t_pwm;
    pw(8'ha8, 10'd32, 3'd1, 256, 10'd64, 2'b11);
    pw(8'hac, 10'd32, 3'd1, 256, 10'd192, 2'b11);
    pw(8'ha0, 10'd32, 3'd1, 256, 10'd192, 2'b11);
    pw(8'haa, 10'd200, 3'd1, 400, 10'd256, 2'b11);
    pw(8'ha8, 10'd300, 3'd1, 256, 10'd256, 2'b10);
    pw(8'h88, 10'd32, 3'd1, 256, 10'd0, 2'b11);
    pw(8'h98, 10'd32, 3'd1, 256, 10'd256, 2'b11);
    pw(8'ha8, 10'd512, 3'd0, 1024, 10'd512, 2'b11);
    $display("pwm done");
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {srst_i, bus_r, clr, n_fail, checks} = '0;
    srst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    t_regs;
    t_cmp;
    t_compare_p_value;
    t_ovf;
    t_pwm;
    conclude;
  end
  // about 4400 cycles expected; generous margin
  initial begin #600us; n_fail++; conclude; end
endmodule // compact_10bit_timer_pwm_tb
bind compact_10bit_timer_pwm compact_10bit_timer_pwm_asserts i_asserts (.clk_i(clk_i),
  .srst_i(srst_i), .bus_i(bus_i), .h_tick_i(h_tick_i), .sub_tick_i(sub_tick_i),
  .ext_clk_i(ext_clk_i), .rdata_o(rdata_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
  .flag_a_o(flag_a_o), .flag_p_o(flag_p_o));
